// File: bench/rbsup_master_model.sv
// Purpose: behavioural fieldbus master facing the supervisor
// Assumes: same clock as the supervisor, link state seen as levels
// Notes: output data change every cycle so a stale image never passes for fresh
module rbsup_master_model #(
  parameter int unsigned SLOTS = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_en,
  input wire logic cfg_en,
  input wire logic [6:0] station,
  input wire logic [6:0] addr_sw,
  output logic comm_ok,
  output logic cfg_received,
  output logic [SLOTS*8-1:0] dout_new,
  output logic [SLOTS*16-1:0] aout_new
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_q;
  logic [6:0] sw_val;
  logic st_ok;
  ////////////////////////////////////////////////////////////////////////////////
  // the first switch is the top bit of the address
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      sw_val[6-i] = addr_sw[i];
    end
  end
  // a station outside 1..112 or unlike the switches never comes up
  assign st_ok = (station >= 7'h01) && (station <= 7'h70) && (station == sw_val);
  assign comm_ok = link_en & st_ok;
  assign cfg_received = cfg_en & comm_ok;
  assign dout_new = {SLOTS{cnt_q}};
  assign aout_new = {SLOTS{cnt_q, ~cnt_q}};
  ////////////////////////////////////////////////////////////////////////////////
  // free-running data pattern
  always_ff @(posedge clk) begin
    cnt_q <= rst ? 8'h01 : cnt_q + 8'h01;
  end
endmodule : rbsup_master_model

// File: bench/rbsup_top_test.sv
// Purpose: self-checking bench for the remote base supervisor
// Assumes: MS_CYCLES shortened to 10, so one ms is ten clocks
// Notes: option pins take effect only through do_reset
module rbsup_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS, RST, DISP_SEL_SW, SPARE_SW, JUMPER_FITTED, JUMPER_FREEZE;
  logic COMM_OK, CFG_RECEIVED, DIAG_FAIL, WRONG_SLOT, REG_WR, REG_RD, ONLINE;
  logic DISP_BLANK, DISP_DP, DISC_UPD, WORD_UPD, link_en, cfg_en;
  logic [1:0] DIAG_KIND;
  logic [3:0] REG_ADDR;
  logic [6:0] ADDR_SW, station;
  logic [7:0] SLOT_CONFIGURED, SLOT_PRESENT, SLOT_MATCH, AOUT_ZERO_SEL, SLOT_UPD_EN, DISP_CHAR;
  logic [31:0] REG_WDATA, REG_RDATA, rv;
  logic [63:0] DOUT_NEW, DOUT, dn;
  logic [127:0] AOUT_NEW, AOUT, asnap;
  int n_errors, checks, g, nw;
  ////////////////////////////////////////////////////////////////////////////////
  rbsup_top #(.MS_CYCLES(10)) i_rbsup_top (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR_SW(ADDR_SW),
    .DISP_SEL_SW(DISP_SEL_SW), .SPARE_SW(SPARE_SW), .JUMPER_FITTED(JUMPER_FITTED),
    .JUMPER_FREEZE(JUMPER_FREEZE), .COMM_OK(COMM_OK), .CFG_RECEIVED(CFG_RECEIVED),
    .DIAG_FAIL(DIAG_FAIL), .DIAG_KIND(DIAG_KIND), .WRONG_SLOT(WRONG_SLOT),
    .SLOT_CONFIGURED(SLOT_CONFIGURED), .SLOT_PRESENT(SLOT_PRESENT), .SLOT_MATCH(SLOT_MATCH),
    .DOUT_NEW(DOUT_NEW), .AOUT_NEW(AOUT_NEW), .AOUT_ZERO_SEL(AOUT_ZERO_SEL),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .DISP_CHAR(DISP_CHAR), .DISP_BLANK(DISP_BLANK), .DISP_DP(DISP_DP),
    .ONLINE(ONLINE), .DISC_UPD(DISC_UPD), .WORD_UPD(WORD_UPD), .SLOT_UPD_EN(SLOT_UPD_EN),
    .DOUT(DOUT), .AOUT(AOUT));
  rbsup_master_model i_rbsup_master_model (.clk(CLK_SYS), .rst(RST), .link_en(link_en),
    .cfg_en(cfg_en), .station(station), .addr_sw(ADDR_SW), .comm_ok(COMM_OK),
    .cfg_received(CFG_RECEIVED), .dout_new(DOUT_NEW), .aout_new(AOUT_NEW));
  ////////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    CLK_SYS = 1'b0;
    forever #10 CLK_SYS = ~CLK_SYS;
  end
  function automatic logic [6:0] rev7(input logic [6:0] v);
    for (int i = 0; i < 7; i++) begin
      rev7[i] = v[6-i];
    end
  endfunction : rev7
  task summarize;
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  task chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk
  // every polling wait goes through here so a hang ends the run
  task guard(inout int n);
    @(posedge CLK_SYS);
    #1;
    n++;
    if (n > 40000) begin
      n_errors++;
      summarize();
    end
  endtask : guard
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge CLK_SYS);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    #1;
    d = REG_RDATA;
  endtask : rd
  task do_reset;
    RST <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'b0;
    repeat (6) @(posedge CLK_SYS);
  endtask : do_reset
  task pins(input logic fit, input logic fz, input logic ds, input logic [6:0] st);
    @(posedge CLK_SYS);
    JUMPER_FITTED <= fit;
    JUMPER_FREEZE <= fz;
    DISP_SEL_SW <= ds;
    SPARE_SW <= ds;
    station <= st;
    ADDR_SW <= rev7(st);
  endtask : pins
  task next_upd(output int n);
    n = 0;
    do guard(n); while (DISC_UPD !== 1'b1);
  endtask : next_upd
  task st(input logic d, input logic [1:0] k, input logic ws, input logic lk, input logic cf,
      input logic [7:0] pr, input logic [7:0] mt, input logic [7:0] ch);
    @(posedge CLK_SYS);
    DIAG_FAIL <= d;
    DIAG_KIND <= k;
    WRONG_SLOT <= ws;
    link_en <= lk;
    cfg_en <= cf;
    SLOT_PRESENT <= pr;
    SLOT_MATCH <= mt;
    repeat (3) @(posedge CLK_SYS);
    #1;
    chk("status char", DISP_CHAR, ch);
  endtask : st
  // data images after the link drops; the snapshot is what the last update left
  task fallback(input logic [63:0] dm, input logic [127:0] am);
    repeat (60) @(posedge CLK_SYS);
    link_en <= 1'b0;
    #1;
    dn = DOUT;
    asnap = AOUT;
    repeat (30) @(posedge CLK_SYS);
    #1;
    chk("dout", DOUT, dn & dm);
    chk("aout", AOUT, asnap & am);
    link_en <= 1'b1;
  endtask : fallback
  task phase(input logic b, input logic [7:0] c, input int len);
    int n;
    n = 0;
    while (n < 20000 && DISP_BLANK === b && (b || DISP_CHAR === c)) guard(n);
    chk("phase length", n, len);
  endtask : phase
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    n_errors = 0;
    checks = 0;
    {REG_WR, REG_RD, DIAG_FAIL, WRONG_SLOT, DISP_SEL_SW, SPARE_SW, JUMPER_FREEZE} = 7'h00;
    {JUMPER_FITTED, link_en, cfg_en} = 3'h7;
    {DIAG_KIND, REG_ADDR, REG_WDATA} = 38'h0;
    station = 7'h05;
    ADDR_SW = rev7(7'h05);
    {SLOT_CONFIGURED, SLOT_PRESENT, SLOT_MATCH, AOUT_ZERO_SEL} = 32'hFFFF_FF0F;
    do_reset();
    rd(rbsup_pkg::REG_CFG, rv);
    chk("cfg reset", rv, 32'h0000_0201);
    @(posedge CLK_SYS);
    #1;
    chk("rdata idle", REG_RDATA, 32'h0);
    rd(rbsup_pkg::REG_STAT, rv);
    chk("stat", rv, 32'h0000_0B30);
    rd(4'h8, rv);
    chk("unmapped", rv, 32'h0);
    wr(rbsup_pkg::REG_STAT, 32'hFFFF_FFFF);
    rd(rbsup_pkg::REG_STAT, rv);
    chk("stat ro", rv, 32'h0000_0B30);
    // zero interval and factor are out of range and must be refused
    wr(rbsup_pkg::REG_CFG, 32'h0001_0000);
    rd(rbsup_pkg::REG_CFG, rv);
    chk("cfg zero", rv, 32'h0001_0201);
    chk("dp", DISP_DP, 1'b1);
    wr(rbsup_pkg::REG_CFG, 32'h0000_0203);
    // interval 3 ms, factor 2: pulses 30 clocks apart, every second one a word update
    nw = 0;
    next_upd(g);
    for (int i = 0; i < 4; i++) begin
      dn = DOUT_NEW;
      asnap = (WORD_UPD === 1'b1) ? AOUT_NEW : AOUT;
      nw += (WORD_UPD === 1'b1);
      chk("slot en", SLOT_UPD_EN, 8'hFF);
      guard(g);
      chk("dout upd", DOUT, dn);
      chk("aout upd", AOUT, asnap);
      next_upd(g);
      chk("gap", g + 1, 30);
    end
    chk("word upd", nw, 2);
    st(1'b1, 2'h0, 1'b0, 1'b1, 1'b1, 8'hFF, 8'hFF, 8'h31);
    st(1'b1, 2'h1, 1'b0, 1'b1, 1'b1, 8'hFF, 8'hFF, 8'h41);
    st(1'b1, 2'h2, 1'b0, 1'b1, 1'b1, 8'hFF, 8'hFF, 8'h45);
    st(1'b1, 2'h3, 1'b0, 1'b1, 1'b1, 8'hFF, 8'hFF, 8'h45);
    st(1'b0, 2'h0, 1'b1, 1'b1, 1'b1, 8'hFF, 8'hFF, 8'h62);
    st(1'b0, 2'h0, 1'b0, 1'b0, 1'b1, 8'hFF, 8'hFF, 8'h33);
    st(1'b0, 2'h0, 1'b0, 1'b1, 1'b0, 8'hFF, 8'hFF, 8'h37);
    st(1'b0, 2'h0, 1'b0, 1'b1, 1'b1, 8'hFF, 8'hFE, 8'h61);
    nw = 0;
    repeat (40) begin
      guard(g);
      nw += (DISC_UPD === 1'b1);
    end
    chk("strict upd", {nw[7:0], SLOT_UPD_EN, 7'h0, ONLINE}, 24'h0);
    st(1'b0, 2'h0, 1'b0, 1'b1, 1'b1, 8'hFE, 8'hFF, 8'h32);
    @(posedge CLK_SYS) SLOT_CONFIGURED <= 8'h7F;
    st(1'b0, 2'h0, 1'b0, 1'b1, 1'b1, 8'hFF, 8'h7F, 8'h30);
    chk("online", ONLINE, 1'b1);
    @(posedge CLK_SYS) SLOT_CONFIGURED <= 8'hFF;
    wr(rbsup_pkg::REG_CFG, 32'h0001_0203);
    st(1'b0, 2'h0, 1'b0, 1'b1, 1'b1, 8'hFF, 8'hFE, 8'h32);
    chk("tol slots", {DISP_DP, ONLINE, SLOT_UPD_EN}, 10'h3FE);
    st(1'b0, 2'h0, 1'b0, 1'b1, 1'b1, 8'hFF, 8'hFF, 8'h30);
    // jumper off: discrete to zero, word slots 0..3 select zero, 4..7 hold
    fallback(64'h0, {64'hFFFF_FFFF_FFFF_FFFF, 64'h0});
    pins(1'b1, 1'b1, 1'b0, 7'h05);
    do_reset();
    rd(rbsup_pkg::REG_STAT, rv);
    chk("freeze bit", rv[19], 1'b1);
    fallback({64{1'b1}}, {128{1'b1}});
    pins(1'b0, 1'b1, 1'b0, 7'h05);
    do_reset();
    fallback(64'h0, {64'hFFFF_FFFF_FFFF_FFFF, 64'h0});
    // pin changes after startup must stay invisible until the next reset
    pins(1'b1, 1'b0, 1'b1, 7'h78);
    repeat (6) @(posedge CLK_SYS);
    rd(rbsup_pkg::REG_STAT, rv);
    chk("late pins", rv[18:9], 10'h005);
    chk("still status", DISP_BLANK, 1'b0);
    do_reset();
    rd(rbsup_pkg::REG_STAT, rv);
    chk("new pins", rv[18:9], 10'h3F8);
    // address 120: digits 1, 2, 0 of 500 ms, blanks 250 ms, then 1000 ms
    g = 0;
    while (!(DISP_BLANK === 1'b0 && DISP_CHAR === 8'h30)) guard(g);
    while (DISP_BLANK !== 1'b1) guard(g);
    phase(1'b1, 8'h00, 10000);
    phase(1'b0, 8'h31, 5000);
    phase(1'b1, 8'h00, 2500);
    phase(1'b0, 8'h32, 5000);
    phase(1'b1, 8'h00, 2500);
    phase(1'b0, 8'h30, 5000);
    summarize();
  end
endmodule : rbsup_top_test

// File: src/rbsup_pkg.sv
// Purpose: shared constants of the remote base supervisor
// Assumes: 50 MHz system clock
// Notes: register offsets are byte addresses on the plain register port
package rbsup_pkg;
  // clock and time base
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  // display phase lengths in milliseconds
  localparam logic [10:0] DIGIT_MS = 11'h1F4;
  localparam logic [10:0] SHORT_MS = 11'h0FA;
  localparam logic [10:0] LONG_MS = 11'h3E8;
  // option switch capture happens this many cycles after reset release
  localparam logic [1:0] STARTUP_CYC = 2'h3;
  // station address limit
  localparam logic [6:0] ADDR_MAX = 7'h70;
  // pacing defaults
  localparam logic [7:0] INTERVAL_DEF = 8'h01;
  localparam logic [7:0] FACTOR_DEF = 8'h02;
  // register map
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam int unsigned CFG_INTV_LSB = 0;
  localparam int unsigned CFG_FACT_LSB = 8;
  localparam int unsigned CFG_TOL_BIT = 16;
  localparam int unsigned STAT_CHAR_LSB = 0;
  localparam int unsigned STAT_ONLINE_BIT = 8;
  localparam int unsigned STAT_ADDR_LSB = 9;
  localparam int unsigned STAT_ADDR_BAD_BIT = 16;
  localparam int unsigned STAT_DSEL_BIT = 17;
  localparam int unsigned STAT_SPARE_BIT = 18;
  localparam int unsigned STAT_FREEZE_BIT = 19;
  // display characters, ascii
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_1 = 8'h31;
  localparam logic [7:0] CH_2 = 8'h32;
  localparam logic [7:0] CH_3 = 8'h33;
  localparam logic [7:0] CH_7 = 8'h37;
  localparam logic [7:0] CH_A_UP = 8'h41;
  localparam logic [7:0] CH_E_UP = 8'h45;
  localparam logic [7:0] CH_A_LO = 8'h61;
  localparam logic [7:0] CH_B_LO = 8'h62;
  // diagnostic failure kinds
  localparam logic [1:0] DIAG_KIND_ONE = 2'h0;
  localparam logic [1:0] DIAG_KIND_A = 2'h1;
  // address display sequencer
  typedef enum logic [2:0] {
    DS_DIGIT = 3'b001,
    DS_SHORT = 3'b010,
    DS_LONG = 3'b100
  } rbsup_disp_e;
endpackage : rbsup_pkg

// File: src/rbsup_sync.sv
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are slow static levels (switches, jumpers)
// Notes: the first stage is read by the second stage only
module rbsup_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // two stages, cleared by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : rbsup_sync

// File: src/rbsup_tick.sv
// Purpose: one-cycle pulse every PERIOD clock cycles
// Assumes: PERIOD of at least 2
// Notes: forms the millisecond base of pacing and display
module rbsup_tick #(
  parameter int unsigned PERIOD = 50000
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  logic [31:0] cnt_q;
  logic wrap;

  if (PERIOD < 2) begin : g_bad_period
    $error("rbsup_tick: PERIOD must be at least 2");
  end

  assign wrap = (cnt_q == 32'(PERIOD - 1));

  // free-running divider; tick is a registered pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 32'h0;
      tick <= 1'b0;
    end else begin
      cnt_q <= wrap ? 32'h0 : cnt_q + 32'h1;
      tick <= wrap;
    end
  end
endmodule : rbsup_tick

// File: src/rbsup_top.sv
// Purpose: supervisor of a fieldbus remote I/O base controller
// Assumes: link, slot scan and diagnostics are same-clock logic; switches are pins
// Notes: status display, option capture, comm-loss fallback, update pacing
// Contract
// R1: display select closed shows address as three digits, pauses short then long
// R2: display select open shows one status character instead of the address
// R3: code 0 when fully operational and online
// R4: code 7 when no configuration received but communication works
// R5: diagnostic failure shows 1, A or E, no communication
// R6: code 2 when installed modules differ from expected configuration
// R7: code 3 when there is no communication with the master
// R8: code a for wrong module in configured slot, strict mode
// R9: code b when the controller sits in the wrong slot
// R10: decimal point lit with status character whenever tolerant mode enabled
// R11: option switches sampled only at startup; changes need a reset
// R12: master uses station addresses 1 through 112 only
// R13: master assigns the same address as the address switches
// R14: on comm loss discrete outputs follow only the jumper
// R15: missing jumper behaves as the off selection
// R16: word outputs zero only for jumper off with module zero
// R17: discrete updates spaced at least interval ms, 1-255, default 1
// R18: word updates once per N discrete updates, 1-255, default 2
// R19: strict mode performs no updates unless configuration matches exactly
// R20: tolerant mode updates matching modules and skips the rest
// R21: address is binary from seven switches, first switch MSB, over 112 invalid
// R22: module in a previously empty slot is ignored
// R23: off de-energises discrete outputs, freeze holds the last state
//
// Our own choices: the register offsets and strobed register access.
module rbsup_top #(
  parameter int unsigned SLOTS = 8,
  parameter int unsigned DW = 8,
  parameter int unsigned AW = 16,
  parameter int unsigned MS_CYCLES = rbsup_pkg::MS_CYCLES
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [6:0] ADDR_SW,
  input wire logic DISP_SEL_SW,
  input wire logic SPARE_SW,
  input wire logic JUMPER_FITTED,
  input wire logic JUMPER_FREEZE,
  input wire logic COMM_OK,
  input wire logic CFG_RECEIVED,
  input wire logic DIAG_FAIL,
  input wire logic [1:0] DIAG_KIND,
  input wire logic WRONG_SLOT,
  input wire logic [SLOTS-1:0] SLOT_CONFIGURED,
  input wire logic [SLOTS-1:0] SLOT_PRESENT,
  input wire logic [SLOTS-1:0] SLOT_MATCH,
  input wire logic [SLOTS*DW-1:0] DOUT_NEW,
  input wire logic [SLOTS*AW-1:0] AOUT_NEW,
  input wire logic [SLOTS-1:0] AOUT_ZERO_SEL,
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  output logic [7:0] DISP_CHAR,
  output logic DISP_BLANK,
  output logic DISP_DP,
  output logic ONLINE,
  output logic DISC_UPD,
  output logic WORD_UPD,
  output logic [SLOTS-1:0] SLOT_UPD_EN,
  output logic [SLOTS*DW-1:0] DOUT,
  output logic [SLOTS*AW-1:0] AOUT
);
  // the spacing check needs at least nine cycles per millisecond tick
  if (SLOTS < 1 || DW < 1 || AW < 1 || MS_CYCLES < 9) begin : g_bad_size
    $error("rbsup_top: SLOTS, DW, AW must be at least 1 and MS_CYCLES at least 9");
  end

  // decimal digit of a station address, idx 0 hundreds, 1 tens, 2 ones
  function automatic logic [3:0] dec_digit(input logic [6:0] v, input logic [1:0] idx);
    logic [6:0] r;
    r = (idx == 2'h0) ? v / 7'd100 : (idx == 2'h1) ? (v / 7'd10) % 7'd10 : v % 7'd10;
    return r[3:0];
  endfunction : dec_digit

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and startup capture
  logic [6:0] addr_sync;
  logic [3:0] opt_sync;
  logic [6:0] addr_q;
  logic disp_sel_q;
  logic spare_q;
  logic freeze_q;
  logic [1:0] start_cnt_q;
  logic opt_done_q;
  logic capture;
  logic addr_bad;

  rbsup_sync #(.W(7)) u_addr_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .d(ADDR_SW),
    .q(addr_sync)
  );

  rbsup_sync #(.W(4)) u_opt_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .d({DISP_SEL_SW, SPARE_SW, JUMPER_FITTED, JUMPER_FREEZE}),
    .q(opt_sync)
  );

  // capture once, when the synchronisers hold settled pin levels
  assign capture = !opt_done_q && (start_cnt_q == rbsup_pkg::STARTUP_CYC - 2'h1);
  assign addr_bad = (addr_q > rbsup_pkg::ADDR_MAX); // see R21

  // switch 0 is the lowest-numbered switch and carries the MSB
  logic [6:0] addr_rev;
  for (genvar i = 0; i < 7; i++) begin : g_addr_rev
    assign addr_rev[i] = addr_sync[6-i]; // see R21
  end

  // options are frozen after capture; only a reset re-reads the switches
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      start_cnt_q <= 2'h0;
      opt_done_q <= 1'b0;
      addr_q <= 7'h00;
      disp_sel_q <= 1'b0;
      spare_q <= 1'b0;
      freeze_q <= 1'b0;
    end else begin
      if (!opt_done_q) start_cnt_q <= start_cnt_q + 2'h1;
      if (capture) begin // see R11
        opt_done_q <= 1'b1;
        addr_q <= addr_rev;
        disp_sel_q <= opt_sync[3];
        spare_q <= opt_sync[2];
        freeze_q <= opt_sync[1] & opt_sync[0]; // see R15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers and register port
  logic [7:0] interval_q;
  logic [7:0] factor_q;
  logic tol_q;
  logic wr_cfg;
  logic [7:0] wr_intv;
  logic [7:0] wr_fact;
  logic [31:0] rd_mux;
  logic [7:0] code_char;

  assign wr_cfg = REG_WR && (REG_ADDR == rbsup_pkg::REG_CFG);
  assign wr_intv = REG_WDATA[rbsup_pkg::CFG_INTV_LSB +: 8];
  assign wr_fact = REG_WDATA[rbsup_pkg::CFG_FACT_LSB +: 8];
  assign rd_mux = (REG_ADDR == rbsup_pkg::REG_CFG) ?
                  {15'h0000, tol_q, factor_q, interval_q} :
                  (REG_ADDR == rbsup_pkg::REG_STAT) ?
                  {12'h000, freeze_q, spare_q, disp_sel_q, addr_bad, addr_q, ONLINE, code_char} :
                  32'h0000_0000;

  // a zero pacing value is outside 1-255 and leaves the field unchanged
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      interval_q <= rbsup_pkg::INTERVAL_DEF; // see R17
      factor_q <= rbsup_pkg::FACTOR_DEF; // see R18
      tol_q <= 1'b0; // see R19
      REG_RDATA <= 32'h0000_0000;
    end else begin
      if (wr_cfg && wr_intv != 8'h00) interval_q <= wr_intv;
      if (wr_cfg && wr_fact != 8'h00) factor_q <= wr_fact;
      if (wr_cfg) tol_q <= REG_WDATA[rbsup_pkg::CFG_TOL_BIT];
      REG_RDATA <= REG_RD ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slot checking and operating condition
  logic [SLOTS-1:0] slot_ok;
  logic [SLOTS-1:0] slot_missing;
  logic [SLOTS-1:0] slot_wrong;
  logic mismatch_any;
  logic wrong_any;
  logic online;
  logic [7:0] diag_char;

  // an unconfigured slot never counts, whatever sits in it
  assign slot_ok = SLOT_CONFIGURED & SLOT_PRESENT & SLOT_MATCH; // see R22
  assign slot_missing = SLOT_CONFIGURED & ~SLOT_PRESENT;
  assign slot_wrong = SLOT_CONFIGURED & SLOT_PRESENT & ~SLOT_MATCH;
  assign mismatch_any = |(slot_missing | slot_wrong);
  assign wrong_any = |slot_wrong;
  // strict mode takes the base offline on any mismatch
  assign online = opt_done_q && COMM_OK && CFG_RECEIVED && !DIAG_FAIL && !WRONG_SLOT &&
                  !(!tol_q && mismatch_any); // see R19
  assign ONLINE = online;

  assign diag_char = (DIAG_KIND == rbsup_pkg::DIAG_KIND_ONE) ? rbsup_pkg::CH_1 :
                     (DIAG_KIND == rbsup_pkg::DIAG_KIND_A) ? rbsup_pkg::CH_A_UP :
                     rbsup_pkg::CH_E_UP; // see R5
  // worst condition wins
  assign code_char = DIAG_FAIL ? diag_char : // see R5
                     WRONG_SLOT ? rbsup_pkg::CH_B_LO : // see R9
                     !COMM_OK ? rbsup_pkg::CH_3 : // see R7
                     !CFG_RECEIVED ? rbsup_pkg::CH_7 : // see R4
                     (!tol_q && wrong_any) ? rbsup_pkg::CH_A_LO : // see R8
                     mismatch_any ? rbsup_pkg::CH_2 : // see R6
                     rbsup_pkg::CH_0; // see R3

  ////////////////////////////////////////////////////////////////////////////
  // millisecond base and update pacing
  logic ms_tick;
  logic [7:0] ms_cnt_q;
  logic [7:0] wcnt_q;
  logic disc_due;

  rbsup_tick #(.PERIOD(MS_CYCLES)) u_tick (
    .clk(CLK_SYS),
    .rst(RST),
    .tick(ms_tick)
  );

  assign disc_due = ms_tick && ({1'b0, ms_cnt_q} + 9'h001 >= {1'b0, interval_q});
  assign DISC_UPD = disc_due && online; // see R17
  assign WORD_UPD = DISC_UPD && ({1'b0, wcnt_q} + 9'h001 >= {1'b0, factor_q}); // see R18
  // tolerant mode skips only the slots that fail their check
  assign SLOT_UPD_EN = online ? slot_ok : {SLOTS{1'b0}}; // see R20

  // the gap counter saturates while offline so the first update after recovery is prompt
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ms_cnt_q <= 8'h00;
      wcnt_q <= 8'h00;
    end else begin
      if (DISC_UPD) ms_cnt_q <= 8'h00;
      else if (ms_tick && ms_cnt_q != 8'hFF) ms_cnt_q <= ms_cnt_q + 8'h01;
      if (WORD_UPD) wcnt_q <= 8'h00;
      else if (DISC_UPD) wcnt_q <= wcnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output images with fallback on communication loss
  for (genvar s = 0; s < SLOTS; s++) begin : g_slot
    always_ff @(posedge CLK_SYS) begin
      if (RST) begin
        DOUT[s*DW +: DW] <= '0;
        AOUT[s*AW +: AW] <= '0;
      end else begin
        if (!online && !freeze_q) DOUT[s*DW +: DW] <= '0; // see R14, R23
        else if (DISC_UPD && SLOT_UPD_EN[s]) DOUT[s*DW +: DW] <= DOUT_NEW[s*DW +: DW];
        if (!online && !freeze_q && AOUT_ZERO_SEL[s]) AOUT[s*AW +: AW] <= '0; // see R16
        else if (WORD_UPD && SLOT_UPD_EN[s]) AOUT[s*AW +: AW] <= AOUT_NEW[s*AW +: AW];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // front display: address sequencer or status character
  rbsup_pkg::rbsup_disp_e ds_q;
  rbsup_pkg::rbsup_disp_e ds_d;
  logic [1:0] didx_q;
  logic [10:0] dcnt_q;
  logic [10:0] phase_len;
  logic phase_done;

  assign phase_len = (ds_q == rbsup_pkg::DS_DIGIT) ? rbsup_pkg::DIGIT_MS :
                     (ds_q == rbsup_pkg::DS_SHORT) ? rbsup_pkg::SHORT_MS : rbsup_pkg::LONG_MS;
  assign phase_done = ms_tick && (dcnt_q == phase_len - 11'h001);

  // next phase: short pause after the first two digits, long after the third
  always_comb begin
    ds_d = ds_q;
    case (ds_q)
      rbsup_pkg::DS_DIGIT: begin
        if (phase_done) ds_d = (didx_q == 2'h2) ? rbsup_pkg::DS_LONG : rbsup_pkg::DS_SHORT; // see R1
      end
      rbsup_pkg::DS_SHORT: begin
        if (phase_done) ds_d = rbsup_pkg::DS_DIGIT;
      end
      rbsup_pkg::DS_LONG: begin
        if (phase_done) ds_d = rbsup_pkg::DS_DIGIT;
      end
      default: begin
        ds_d = rbsup_pkg::DS_DIGIT;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      ds_q <= rbsup_pkg::DS_DIGIT;
      didx_q <= 2'h0;
      dcnt_q <= 11'h000;
    end else begin
      ds_q <= ds_d;
      dcnt_q <= phase_done ? 11'h000 : (ms_tick ? dcnt_q + 11'h001 : dcnt_q);
      if (phase_done && ds_q == rbsup_pkg::DS_SHORT) didx_q <= didx_q + 2'h1;
      if (phase_done && ds_q == rbsup_pkg::DS_LONG) didx_q <= 2'h0;
    end
  end

  // display is blank until the options are known; point only in status mode
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      DISP_CHAR <= 8'h00;
      DISP_BLANK <= 1'b1;
      DISP_DP <= 1'b0;
    end else if (disp_sel_q) begin
      DISP_CHAR <= rbsup_pkg::CH_0 + {4'h0, dec_digit(addr_q, didx_q)}; // see R1
      DISP_BLANK <= !opt_done_q || (ds_q != rbsup_pkg::DS_DIGIT); // see R1
      DISP_DP <= 1'b0;
    end else begin
      DISP_CHAR <= code_char; // see R2
      DISP_BLANK <= !opt_done_q;
      DISP_DP <= tol_q && opt_done_q; // see R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  chk_word_ratio: assert property (WORD_UPD |-> DISC_UPD) // see R18
    else $error("word update without discrete update");
  chk_strict_block: assert property (!tol_q && mismatch_any |-> !DISC_UPD && SLOT_UPD_EN == '0) // see R19
    else $error("update during strict mismatch");
  chk_tol_skip: assert property (DISC_UPD && tol_q |-> SLOT_UPD_EN == slot_ok) // see R20
    else $error("tolerant mode slot selection wrong");
  chk_disc_spacing: assert property (DISC_UPD |=> !DISC_UPD [*8]) // see R17
    else $error("discrete updates too close");
  chk_dout_off: assert property (!online && !freeze_q |=> DOUT == '0) // see R14
    else $error("discrete outputs not de-energised");
  chk_dout_freeze: assert property (!online && freeze_q |=> $stable(DOUT)) // see R23
    else $error("frozen outputs changed");
  chk_aout_hold: assert property (!online && (freeze_q || AOUT_ZERO_SEL == '0) |=> $stable(AOUT)) // see R16
    else $error("word outputs not held");
  chk_dp_tolerant: assert property (opt_done_q && !disp_sel_q |=> DISP_DP == $past(tol_q)) // see R10
    else $error("decimal point wrong");
  chk_code_three: assert property (opt_done_q && !disp_sel_q && !COMM_OK && // see R7
                                   !DIAG_FAIL && !WRONG_SLOT |=> DISP_CHAR == rbsup_pkg::CH_3)
    else $error("no-communication code missing");
  chk_opts_frozen: assert property (opt_done_q |=> $stable(disp_sel_q) && $stable(freeze_q)) // see R11
    else $error("options changed after startup");
  chk_long_blank: assert property (disp_sel_q && ds_q == rbsup_pkg::DS_LONG |=> DISP_BLANK) // see R1
    else $error("display not blank in long pause");

  cov_disc_upd: cover property (DISC_UPD);
  cov_word_upd: cover property (WORD_UPD);
  cov_long_pause: cover property (ds_q == rbsup_pkg::DS_LONG && phase_done);
  cov_code_a: cover property (code_char == rbsup_pkg::CH_A_LO);
endmodule : rbsup_top
